// ---- tb_vmon_core.sv ----
`timescale 1ns/1ps
module tb_vmon_core;
    import vmon_pkg::*;

    // Design inputs and outputs
    logic mclk_i, rst_i, reg_wr_i, reg_rd_i, reg_ack_o, link_6g_i;
    logic [15:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o;
    vmon_pkt_ev_type pkt_ev_i;
    vmon_sync_type [1:0] sync_i;
    vmon_mult_type [1:0] mult_i;
    logic [1:0] tunnel_i, cmp_en_i, err_clr_i, line_drop_o, frame_drop_o, over_budget_o;
    logic [1:0][4:0] dt_bpp_i, pipe_bpp_o;
    logic [1:0][11:0] pclk_mhz_i;
    logic [1:0][15:0] exp_lines_i, line_count_o, frame_count_o;
    logic [1:0][23:0] frame_max_i;
    logic [1:0][7:0] link_count_o;
    logic [1:0][16:0] link_load_o;
    logic multifunction_pin_zero_o, multifunction_pin_zero_oe_o;
    logic multifunction_pin_three_o, multifunction_pin_three_oe_o;
    int num_errors = 0;
    int checked = 0;

    // Short activity window keeps the run brief
    vmon_core #(.ACT_CYC(ACT_W'(16))) dut (
        .mclk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
        .reg_ack_o, .pkt_ev_i, .sync_i, .tunnel_i, .mult_i, .dt_bpp_i, .pclk_mhz_i,
        .link_6g_i, .cmp_en_i, .exp_lines_i, .frame_max_i, .err_clr_i, .link_count_o,
        .line_count_o, .frame_count_o, .line_drop_o, .frame_drop_o, .pipe_bpp_o,
        .link_load_o, .over_budget_o, .multifunction_pin_zero_o,
        .multifunction_pin_zero_oe_o, .multifunction_pin_three_o,
        .multifunction_pin_three_oe_o
    );

    // Clock generator
    initial
    begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    // Prints the counts and the verdict, then stops
    task automatic tally_and_finish();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    // Compares a seen value with an expected one
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    // Waits n rising edges, then a small drive delay
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tick

    // Register write, one-cycle strobe
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        tick(1);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        tick(1);
        reg_wr_i = 1'b0;
    endtask : wr

    // Register read, waits for the answer under a bound, compares masked data
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic [7:0] m);
        int n;
        tick(1);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        tick(1);
        reg_rd_i = 1'b0;
        n = 0;
        while (reg_ack_o !== 1'b1)
        begin
            if (n == 4)
            begin
                num_errors++;
                tally_and_finish();
            end
            tick(1);
            n++;
        end
        check(reg_rdata_o & m, exp);
    endtask : rd

    // One frame on the first pipe: a vsync pulse, then lines with low hsync pulses
    task automatic frame(input int lines);
        sync_i[0].vs = 1'b1;
        tick(1);
        sync_i[0].vs = 1'b0;
        repeat (lines)
        begin
            sync_i[0].hs = 1'b0;
            sync_i[0].de = 1'b0;
            tick(1);
            sync_i[0].hs = 1'b1;
            sync_i[0].de = 1'b1;
            tick(3);
        end
    endtask : frame

    // Main sequence
    initial
    begin
        logic [15:0] ra [8] = '{16'h0342, 16'h0343, 16'h0344, 16'h0345,
                                16'h0540, 16'h0541, 16'h0542, 16'h0100};
        int cnt [10] = '{17, 1, 2, 3, 4, 5, 6, 15, 17, 3};
        logic [9:0] ev;
        logic tn [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
        logic [1:0] mu [6] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0};
        logic [4:0] dt [6] = '{5'h08, 5'h08, 5'h08, 5'h08, 5'h0C, 5'h05};
        logic [4:0] eb [6] = '{5'h18, 5'h10, 5'h18, 5'h09, 5'h0C, 5'h09};
        int ld;
        rst_i = 1'b1;
        reg_addr_i = 16'h0000;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_wdata_i = 8'h00;
        pkt_ev_i = '0;
        sync_i = 6'h01;
        tunnel_i = 2'h0;
        mult_i[0] = VMON_MULT_NONE;
        mult_i[1] = VMON_MULT_NONE;
        dt_bpp_i = '0;
        pclk_mhz_i = {12'h064, 12'h064};
        link_6g_i = 1'b0;
        cmp_en_i = 2'h3;
        exp_lines_i = {16'h0003, 16'h0003};
        frame_max_i = {24'h000032, 24'h000032};
        err_clr_i = 2'h0;
        tick(2);
        rst_i = 1'b0;
        // Reset values, an unmapped address among them
        foreach (ra[i]) rd(ra[i], 8'h00, 8'hFF);
        // Packet pulses on every input, back to back, the first control count past a wrap
        for (int i = 0; i < 17; i++)
        begin
            foreach (cnt[b]) ev[b] = (i < cnt[b]);
            pkt_ev_i = vmon_pkt_ev_type'(ev);
            tick(1);
        end
        pkt_ev_i = '0;
        tick(1);
        rd(16'h0342, 8'h11, 8'hFF);
        rd(16'h0343, 8'h32, 8'hFF);
        rd(16'h0344, 8'h54, 8'hFF);
        rd(16'h0345, 8'hF6, 8'hFF);
        check(link_count_o, 16'h0311);
        wr(16'h0342, 8'hFF);
        rd(16'h0342, 8'h11, 8'hFF);
        // Pin zero follows vsync of the chosen pipe
        for (int s = 1; s < 3; s++)
        begin
            wr(16'h0541, 8'(s << 5));
            rd(16'h0541, 8'(s << 5), 8'hFF);
            for (int v = 0; v < 2; v++)
            begin
                sync_i[s-1].vs = v[0];
                tick(2);
                check({multifunction_pin_zero_oe_o, multifunction_pin_zero_o}, {1'b1, v[0]});
            end
            sync_i[s-1].vs = 1'b0;
        end
        wr(16'h0541, 8'hE0);
        tick(1);
        check({multifunction_pin_zero_oe_o, multifunction_pin_zero_o}, 2'h0);
        wr(16'h0541, 8'h5F);
        rd(16'h0541, 8'h40, 8'hFF);
        // Pin three: hsync select, then the vsync select takes over
        wr(16'h0542, 8'h20);
        tick(1);
        check({multifunction_pin_three_oe_o, multifunction_pin_three_o}, 2'h3);
        wr(16'h0540, 8'h40);
        tick(1);
        check({multifunction_pin_three_oe_o, multifunction_pin_three_o}, 2'h2);
        // Pipe format table on both pipes, load on the first pipe, budget on the second
        foreach (tn[i])
        begin
            tunnel_i = {tn[i], tn[i]};
            // Element by element keeps the enum type intact
            foreach (mult_i[p]) mult_i[p] = vmon_mult_type'(mu[i]);
            dt_bpp_i = {dt[i], dt[i]};
            link_6g_i = i[0];
            tick(4);
            ld = 100 * (int'(eb[i]) + 1) * 20480 / 18423;
            check(pipe_bpp_o, {eb[i], eb[i]});
            check(link_load_o[0], 17'(ld));
            check(over_budget_o[1], (ld > (i[0] ? 5200 : 2600)));
        end
        // Second pipe activity
        sync_i[1].de = 1'b1;
        tick(1);
        rd(16'h0576, 8'h40, 8'h70);
        // Frames on the first pipe with status read mid-stream
        fork
            repeat (4) frame(3);
            begin
                tick(30);
                rd(16'h0575, 8'h72, 8'h73);
            end
        join
        err_clr_i = 2'h1;
        tick(1);
        err_clr_i = 2'h0;
        frame(3);
        frame(3);
        check(line_count_o[0], 16'h0003);
        check({line_drop_o[0], frame_drop_o[0]}, 2'h0);
        frame(2);
        frame(3);
        check(line_drop_o[0], 1'b1);
        tick(50);
        check(frame_drop_o[0], 1'b1);
        // One vsync lead per pipe from the pin test, eight more frames on the first pipe
        check(frame_count_o, {16'h0001, 16'h0009});
        rd(16'h0575, 8'h02, 8'h73);
        err_clr_i = 2'h1;
        tick(1);
        err_clr_i = 2'h0;
        check({line_drop_o[0], frame_drop_o[0]}, 2'h0);
        // Reset in mid-run clears counters and selectors
        rst_i = 1'b1;
        tick(2);
        rst_i = 1'b0;
        rd(16'h0342, 8'h00, 8'hFF);
        rd(16'h0541, 8'h00, 8'hFF);
        check(link_count_o, 16'h0000);
        tally_and_finish();
    end
endmodule : tb_vmon_core

// ---- vmon_core.sv ----
`timescale 1ns/1ps
module vmon_core
    import vmon_pkg::*;
#(
    parameter logic [ACT_W-1:0] ACT_CYC = ACT_WIN_CYC
)
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_ack_o,
    // Packet events and pipe syncs
    input vmon_pkt_ev_type pkt_ev_i,
    input vmon_sync_type [1:0] sync_i,
    // Pipe format and comparator setup
    input wire logic [1:0] tunnel_i,
    input vmon_mult_type [1:0] mult_i,
    input wire logic [1:0][4:0] dt_bpp_i,
    input wire logic [1:0][11:0] pclk_mhz_i,
    input wire logic link_6g_i,
    input wire logic [1:0] cmp_en_i,
    input wire logic [1:0][15:0] exp_lines_i,
    input wire logic [1:0][23:0] frame_max_i,
    input wire logic [1:0] err_clr_i,
    // Status outputs
    output logic [1:0][7:0] link_count_o,
    output logic [1:0][15:0] line_count_o,
    output logic [1:0][15:0] frame_count_o,
    output logic [1:0] line_drop_o,
    output logic [1:0] frame_drop_o,
    output logic [1:0][4:0] pipe_bpp_o,
    output logic [1:0][16:0] link_load_o,
    output logic [1:0] over_budget_o,
    // Multifunction pins
    output logic multifunction_pin_zero_o,
    output logic multifunction_pin_zero_oe_o,
    output logic multifunction_pin_three_o,
    output logic multifunction_pin_three_oe_o
);

    vmon_state_type q;
    vmon_state_type d;
    logic [7:0] pkt_vec;
    logic [1:0] lead_v;
    logic [1:0] lead_h;

    // Selector register index of an address
    function automatic logic [1:0] sel_idx(input logic [15:0] a);
        case (a)
            ADDR_VS_SEL_FIRST: sel_idx = 2'h0;
            ADDR_VS_SEL_SECOND: sel_idx = 2'h1;
            ADDR_HS_SEL_FIRST: sel_idx = 2'h2;
            default: sel_idx = SEL_IDX_NONE;
        endcase
    endfunction : sel_idx

    // Route code: bit 1 valid, bit 0 pipe number
    function automatic logic [1:0] route(input logic [2:0] s);
        case (s)
            SEL_FIRST: route = 2'h2;
            SEL_SECOND: route = 2'h3;
            default: route = 2'h0;
        endcase
    endfunction : route

    // Status byte of one pipe
    function automatic logic [7:0] stat_byte(input vmon_state_type s, input int p);
        stat_byte = {1'b0, s.act[p][2] != '0, s.act[p][1] != '0,
            s.act[p][0] != '0, 2'b00, s.pol[p][1][7], s.pol[p][0][7]};
    endfunction : stat_byte

    assign pkt_vec = {pkt_ev_i.phy, pkt_ev_i.dup, pkt_ev_i.ctrl};

    // Next state of the whole block
    always_comb
    begin
        logic [1:0] sidx;
        logic [1:0] rt;
        logic [2:0] cur;
        logic pv;
        logic ph;
        logic [31:0] prod;
        d = q;
        sidx = sel_idx(reg_addr_i);
        rt = 2'h0;
        cur = 3'h0;
        pv = 1'b0;
        ph = 1'b0;
        prod = 32'h0;
        lead_v = 2'h0;
        lead_h = 2'h0;
        d.ack = 1'b0;
        // Nibble packet counters, wrapping silently
        for (int i = 0; i < 8; i++)
        begin
            if (pkt_vec[i])
                d.nib[i] = q.nib[i] + 4'h1;
        end
        // Serial link received packet counters
        for (int l = 0; l < 2; l++)
        begin
            if (pkt_ev_i.link[l])
                d.link[l] = q.link[l] + 8'h01;
        end
        // Selector writes keep only bits 7:5
        if (reg_wr_i && sidx != SEL_IDX_NONE)
            d.sel[sidx] = reg_wdata_i[SEL_MSB:SEL_LSB];
        // Register reads
        if (reg_rd_i)
        begin
            d.ack = 1'b1;
            case (reg_addr_i)
                ADDR_CTRL_CNT: d.rdata = {q.nib[1], q.nib[0]};
                ADDR_DUP_CNT: d.rdata = {q.nib[3], q.nib[2]};
                ADDR_PHY_LO_CNT: d.rdata = {q.nib[5], q.nib[4]};
                ADDR_PHY_HI_CNT: d.rdata = {q.nib[7], q.nib[6]};
                ADDR_STAT_FIRST: d.rdata = stat_byte(q, 0);
                ADDR_STAT_SECOND: d.rdata = stat_byte(q, 1);
                default:
                begin
                    if (sidx != SEL_IDX_NONE)
                        d.rdata = {q.sel[sidx], 5'h00};
                    else
                        d.rdata = 8'h00;
                end
            endcase
        end
        // Per pipe sync watch, counters and format
        for (int p = 0; p < 2; p++)
        begin
            cur = sync_i[p];
            // Activity: any change reloads the window
            for (int s = 0; s < 3; s++)
            begin
                if (cur[s] != q.prev[p][s])
                    d.act[p][s] = ACT_CYC;
                else if (q.act[p][s] != '0)
                    d.act[p][s] = q.act[p][s] - ACT_W'(1);
            end
            d.prev[p] = cur;
            // Polarity: the level held longer is the idle level
            for (int s = 0; s < 2; s++)
            begin
                if (cur[s] && q.pol[p][s] != POL_MAX)
                    d.pol[p][s] = q.pol[p][s] + 8'h01;
                else if (!cur[s] && q.pol[p][s] != POL_MIN)
                    d.pol[p][s] = q.pol[p][s] - 8'h01;
            end
            // Leading edges of the active level
            pv = q.pol[p][1][7];
            ph = q.pol[p][0][7];
            lead_v[p] = ~(cur[1] ^ pv) & (q.prev[p][1] ^ pv);
            lead_h[p] = ~(cur[0] ^ ph) & (q.prev[p][0] ^ ph);
            // Line and frame counters with drop comparators
            if (err_clr_i[p])
            begin
                d.line_err[p] = 1'b0;
                d.frame_err[p] = 1'b0;
            end
            d.ftimer[p] = q.ftimer[p] + 24'h000001;
            if (cmp_en_i[p] && q.ftimer[p] == frame_max_i[p])
                d.frame_err[p] = 1'b1;
            if (lead_h[p])
                d.lines[p] = q.lines[p] + 16'h0001;
            if (lead_v[p])
            begin
                d.frames[p] = q.frames[p] + 16'h0001;
                d.lines[p] = 16'h0000;
                d.ftimer[p] = 24'h000000;
                if (cmp_en_i[p] && q.lines[p] != exp_lines_i[p])
                    d.line_err[p] = 1'b1;
            end
            // Pipe bits per pixel
            if (tunnel_i[p])
                d.bpp[p] = BPP_TUNNEL;
            else if (dt_bpp_i[p] == BPP_RAW8 && mult_i[p] == VMON_MULT_DOUBLE)
                d.bpp[p] = BPP_DOUBLE;
            else if (dt_bpp_i[p] == BPP_RAW8 && mult_i[p] == VMON_MULT_TRIPLE)
                d.bpp[p] = BPP_TRIPLE;
            else if (dt_bpp_i[p] < BPP_MIN)
                d.bpp[p] = BPP_MIN;
            else
                d.bpp[p] = dt_bpp_i[p];
            // Link load in Mbps from the current bpp
            prod = {20'h0, pclk_mhz_i[p]} * ({27'h0, q.bpp[p]} + 32'h1);
            prod = (prod * ENC_NUM * SYNC_NUM) / (ENC_DEN * SYNC_DEN);
            d.load[p] = prod[16:0];
            d.over[p] = q.load[p] > (link_6g_i ? BUDGET_6G : BUDGET_3G);
        end
        // Pin zero from the second vsync selector
        rt = route(q.sel[1]);
        d.oe0 = rt[1];
        d.pin0 = rt[1] & sync_i[rt[0]].vs;
        // Pin three: vsync selector first, else hsync selector
        rt = route(q.sel[0]);
        if (rt[1])
        begin
            d.oe3 = 1'b1;
            d.pin3 = sync_i[rt[0]].vs;
        end
        else
        begin
            rt = route(q.sel[2]);
            d.oe3 = rt[1];
            d.pin3 = rt[1] & sync_i[rt[0]].hs;
        end
    end

    // State register
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            q <= '0;
        else
            q <= d;
    end

    // Outputs straight from state
    assign reg_rdata_o = q.rdata;
    assign reg_ack_o = q.ack;
    assign link_count_o = q.link;
    assign line_count_o = q.lines;
    assign frame_count_o = q.frames;
    assign line_drop_o = q.line_err;
    assign frame_drop_o = q.frame_err;
    assign pipe_bpp_o = q.bpp;
    assign link_load_o = q.load;
    assign over_budget_o = q.over;
    assign multifunction_pin_zero_o = q.pin0;
    assign multifunction_pin_zero_oe_o = q.oe0;
    assign multifunction_pin_three_o = q.pin3;
    assign multifunction_pin_three_oe_o = q.oe3;

    // Checks
    property p_nib_wrap;
        @(posedge mclk_i) disable iff (rst_i)
        pkt_ev_i.ctrl[0] && q.nib[0] == 4'hF |=> q.nib[0] == 4'h0;
    endproperty
    a_nib_wrap: assert property (p_nib_wrap) else $error("nibble did not wrap");

    property p_phy_count;
        @(posedge mclk_i) disable iff (rst_i)
        pkt_ev_i.phy[0] |=> q.nib[4] == $past(q.nib[4]) + 4'h1;
    endproperty
    a_phy_count: assert property (p_phy_count) else $error("phy count missed");

    property p_ctrl_hold;
        @(posedge mclk_i) disable iff (rst_i)
        !pkt_ev_i.ctrl[1] |=> $stable(q.nib[1]);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("idle count moved");

    property p_link_count;
        @(posedge mclk_i) disable iff (rst_i)
        pkt_ev_i.link[0] |=> link_count_o[0] == $past(link_count_o[0]) + 8'h01;
    endproperty
    a_link_count: assert property (p_link_count) else $error("link count missed");

    property p_route_zero;
        @(posedge mclk_i) disable iff (rst_i)
        q.sel[1] == SEL_FIRST |=> multifunction_pin_zero_oe_o &&
            multifunction_pin_zero_o == $past(sync_i[0].vs);
    endproperty
    a_route_zero: assert property (p_route_zero) else $error("pin zero misrouted");

    property p_sel_none;
        @(posedge mclk_i) disable iff (rst_i)
        q.sel[1] == SEL_NONE |=> !multifunction_pin_zero_oe_o;
    endproperty
    a_sel_none: assert property (p_sel_none) else $error("pin zero driven");

    property p_seen_first;
        @(posedge mclk_i) disable iff (rst_i)
        sync_i[0].vs != q.prev[0][1] |=> q.act[0][1] == ACT_CYC;
    endproperty
    a_seen_first: assert property (p_seen_first) else $error("vsync edge unseen");

    property p_seen_second;
        @(posedge mclk_i) disable iff (rst_i)
        reg_rd_i && reg_addr_i == ADDR_STAT_SECOND |=>
            reg_ack_o && reg_rdata_o[6] == ($past(q.act[1][2]) != '0);
    endproperty
    a_seen_second: assert property (p_seen_second) else $error("de status wrong");

    property p_pol_read;
        @(posedge mclk_i) disable iff (rst_i)
        reg_rd_i && reg_addr_i == ADDR_STAT_FIRST |=>
            reg_rdata_o[1:0] == {$past(q.pol[0][1][7]), $past(q.pol[0][0][7])};
    endproperty
    a_pol_read: assert property (p_pol_read) else $error("polarity wrong");

    property p_line_drop;
        @(posedge mclk_i) disable iff (rst_i)
        lead_v[0] && cmp_en_i[0] && q.lines[0] != exp_lines_i[0] |=> line_drop_o[0];
    endproperty
    a_line_drop: assert property (p_line_drop) else $error("line drop missed");

    property p_bpp_min;
        @(posedge mclk_i) disable iff (rst_i)
        !tunnel_i[1] |=> pipe_bpp_o[1] >= BPP_MIN;
    endproperty
    a_bpp_min: assert property (p_bpp_min) else $error("bpp below minimum");

    property p_tunnel;
        @(posedge mclk_i) disable iff (rst_i)
        tunnel_i[0] |=> pipe_bpp_o[0] == BPP_TUNNEL;
    endproperty
    a_tunnel: assert property (p_tunnel) else $error("tunnel bpp wrong");

    property p_double;
        @(posedge mclk_i) disable iff (rst_i)
        !tunnel_i[0] && dt_bpp_i[0] == BPP_RAW8 && mult_i[0] == VMON_MULT_DOUBLE
            |=> pipe_bpp_o[0] == BPP_DOUBLE;
    endproperty
    a_double: assert property (p_double) else $error("doubled bpp wrong");

    property p_load;
        @(posedge mclk_i) disable iff (rst_i)
        pclk_mhz_i[0] == 12'h064 && q.bpp[0] == BPP_TUNNEL |=> link_load_o[0] == 17'h00ADB;
    endproperty
    a_load: assert property (p_load) else $error("link load wrong");

endmodule : vmon_core

// ---- vmon_pkg.sv ----
package vmon_pkg;

    // Register addresses
    localparam logic [15:0] ADDR_CTRL_CNT = 16'h0342;
    localparam logic [15:0] ADDR_DUP_CNT = 16'h0343;
    localparam logic [15:0] ADDR_PHY_LO_CNT = 16'h0344;
    localparam logic [15:0] ADDR_PHY_HI_CNT = 16'h0345;
    localparam logic [15:0] ADDR_VS_SEL_FIRST = 16'h0540;
    localparam logic [15:0] ADDR_VS_SEL_SECOND = 16'h0541;
    localparam logic [15:0] ADDR_HS_SEL_FIRST = 16'h0542;
    localparam logic [15:0] ADDR_STAT_FIRST = 16'h0575;
    localparam logic [15:0] ADDR_STAT_SECOND = 16'h0576;

    // Selector field and codes
    localparam int SEL_LSB = 5;
    localparam int SEL_MSB = 7;
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_FIRST = 3'h1;
    localparam logic [2:0] SEL_SECOND = 3'h2;
    localparam logic [1:0] SEL_IDX_NONE = 2'h3;

    // Bits per pixel figures
    localparam logic [4:0] BPP_RAW8 = 5'h08;
    localparam logic [4:0] BPP_MIN = 5'h09;
    localparam logic [4:0] BPP_DOUBLE = 5'h10;
    localparam logic [4:0] BPP_TRIPLE = 5'h18;
    localparam logic [4:0] BPP_TUNNEL = 5'h18;

    // Link load overhead factors and payload budgets in Mbps
    localparam logic [31:0] ENC_NUM = 32'h0000000A;
    localparam logic [31:0] ENC_DEN = 32'h00000009;
    localparam logic [31:0] SYNC_NUM = 32'h00000800;
    localparam logic [31:0] SYNC_DEN = 32'h000007FF;
    localparam logic [16:0] BUDGET_3G = 17'h00A28;
    localparam logic [16:0] BUDGET_6G = 17'h01450;

    // Activity window: time in us, cycles derived from the clock rate
    localparam int CLK_MHZ = 200;
    localparam int ACT_WIN_US = 10000;
    localparam int ACT_W = 22;
    localparam logic [ACT_W-1:0] ACT_WIN_CYC = ACT_W'(ACT_WIN_US * CLK_MHZ);

    // Polarity accumulator limits
    localparam logic [7:0] POL_MAX = 8'h7F;
    localparam logic [7:0] POL_MIN = 8'h80;

    typedef enum logic [1:0] {
        VMON_MULT_NONE,
        VMON_MULT_DOUBLE,
        VMON_MULT_TRIPLE
    } vmon_mult_type;

    // Packet events, one-cycle pulses
    typedef struct packed {
        logic [1:0] link;
        logic [3:0] phy;
        logic [1:0] dup;
        logic [1:0] ctrl;
    } vmon_pkt_ev_type;

    // Sync triplet of one pipe
    typedef struct packed {
        logic de;
        logic vs;
        logic hs;
    } vmon_sync_type;

    // Whole block state
    typedef struct packed {
        logic [7:0][3:0] nib;
        logic [1:0][7:0] link;
        logic [2:0][2:0] sel;
        logic [1:0][2:0] prev;
        logic [1:0][2:0][ACT_W-1:0] act;
        logic [1:0][1:0][7:0] pol;
        logic [1:0][15:0] lines;
        logic [1:0][15:0] frames;
        logic [1:0][23:0] ftimer;
        logic [1:0] line_err;
        logic [1:0] frame_err;
        logic [1:0][4:0] bpp;
        logic [1:0][16:0] load;
        logic [1:0] over;
        logic [7:0] rdata;
        logic ack;
        logic pin0;
        logic pin3;
        logic oe0;
        logic oe3;
    } vmon_state_type;

endpackage : vmon_pkg
